// ---- design/timer8_pkg.sv ----
// Constants, register map and field positions of the 8-bit compare/pulse/PWM timer.
// Assumes a 125 MHz CPU clock and a 32-bit classic Wishbone register bus.
package timer8_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL1 = 8'h00;
  localparam logic [7:0] ADDR_CTRL2 = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_CAP1 = 8'h0C;
  localparam logic [7:0] ADDR_CAP2 = 8'h10;
  localparam logic [7:0] ADDR_CMP1 = 8'h14;
  localparam logic [7:0] ADDR_CMP2 = 8'h18;
  localparam logic [7:0] ADDR_COUNT = 8'h1C;
  // ----------------------------------------------------------------
  // Control 1 fields
  // ----------------------------------------------------------------
  localparam int CR1_CAP_IE = 7;
  localparam int CR1_CMP_IE = 6;
  localparam int CR1_OVF_IE = 5;
  localparam int CR1_FORCE2 = 4;
  localparam int CR1_FORCE1 = 3;
  localparam int CR1_LEVEL2 = 2;
  localparam int CR1_EDGE1 = 1;
  localparam int CR1_LEVEL1 = 0;
  // ----------------------------------------------------------------
  // Control 2 fields
  // ----------------------------------------------------------------
  localparam int CR2_PIN1_EN = 7;
  localparam int CR2_PIN2_EN = 6;
  localparam int CR2_ONE_PULSE = 5;
  localparam int CR2_PWM = 4;
  localparam int CR2_DIV_HI = 3;
  localparam int CR2_DIV_LO = 2;
  localparam int CR2_EDGE2 = 1;
  localparam logic [7:0] CR2_WMASK = 8'hFE;
  // ----------------------------------------------------------------
  // Flag vector order: capture1, compare1, overflow, capture2, compare2
  // ----------------------------------------------------------------
  localparam int NFLAGS = 5;
  localparam int FL_CAP1 = 4;
  localparam int FL_CMP1 = 3;
  localparam int FL_OVF = 2;
  localparam int FL_CAP2 = 1;
  localparam int FL_CMP2 = 0;
  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] COUNT_RELOAD = 8'hFC;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] CMP_LATE = 8'h01;
  // Low byte of the FFFDh trigger capture value
  localparam logic [7:0] PULSE_CAPTURE = 8'hFD;
  // ----------------------------------------------------------------
  // Tick divider select and last counts of the divider
  // ----------------------------------------------------------------
  localparam logic [1:0] DIV_SEL_4 = 2'h0;
  localparam logic [1:0] DIV_SEL_2 = 2'h1;
  localparam logic [1:0] DIV_SEL_8 = 2'h2;
  localparam int CLK_MHZ = 125;
  localparam logic [12:0] DIV_LAST_2 = 13'h0001;
  localparam logic [12:0] DIV_LAST_4 = 13'h0003;
  localparam logic [12:0] DIV_LAST_8 = 13'h0007;
  localparam logic [12:0] DIV_LAST_8000 = 13'h1F3F;
  localparam logic [12:0] DIV_ONE = 13'h0001;
endpackage

// ---- design/timer8_compare_pulse_pwm.sv ----
// 8-bit free-running timer with output compare, forced compare, one-pulse and PWM modes.
// Assumes a Wishbone classic master on CLK; capture pins are asynchronous to CLK.
`timescale 1ns/100ps
module timer8_compare_pulse_pwm
  import timer8_pkg::*;
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic CE,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic CAPTURE1_IN_PIN,
  input wire logic CAPTURE2_IN_PIN,
  output logic COMPARE1_OUT_PIN,
  output logic COMPARE1_OUT_OE,
  output logic COMPARE2_OUT_PIN,
  output logic COMPARE2_OUT_OE,
  output logic TIMER_IRQ
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] ctrl1_r, ctrl2_r;
  logic [7:0] cap1_r, cap2_r, cnt_r;
  logic [7:0] cmp1_sw_r, cmp2_sw_r, cmp1_act_r, cmp2_act_r;
  logic [12:0] div_r;
  logic tick_d_r, ack_r, irq_r, out1_r, out2_r, oe1_r, oe2_r;
  logic [7:0] dat_r;
  logic [1:0] sync1_r, sync2_r;
  logic pin1_d_r, pin2_d_r;
  logic [NFLAGS-1:0] flag_r, armed_r;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire req = WB_CYC_I & WB_STB_I & ~ack_r;
  wire acc = WB_CYC_I & WB_STB_I & ack_r;
  wire wr = acc & WB_WE_I & WB_SEL_I[0];
  wire rd_flags = acc & ~WB_WE_I & (WB_ADR_I == ADDR_FLAGS);
  wire wr_ctrl1 = wr & (WB_ADR_I == ADDR_CTRL1);
  wire wr_ctrl2 = wr & (WB_ADR_I == ADDR_CTRL2);
  wire wr_cmp1 = wr & (WB_ADR_I == ADDR_CMP1);
  wire wr_cmp2 = wr & (WB_ADR_I == ADDR_CMP2);
  wire [7:0] wdata = WB_DAT_I[7:0];
  wire [NFLAGS-1:0] acc_sel = {acc & (WB_ADR_I == ADDR_CAP1), acc & (WB_ADR_I == ADDR_CMP1),
                               acc & (WB_ADR_I == ADDR_COUNT), acc & (WB_ADR_I == ADDR_CAP2),
                               acc & (WB_ADR_I == ADDR_CMP2)};
  logic [7:0] rd_mux;
  always_comb begin
    if (WB_ADR_I == ADDR_CTRL1) begin
      rd_mux = ctrl1_r;
    end else if (WB_ADR_I == ADDR_CTRL2) begin
      rd_mux = ctrl2_r;
    end else if (WB_ADR_I == ADDR_FLAGS) begin
      rd_mux = {flag_r, 3'h0};
    end else if (WB_ADR_I == ADDR_CAP1) begin
      rd_mux = cap1_r;
    end else if (WB_ADR_I == ADDR_CAP2) begin
      rd_mux = cap2_r;
    end else if (WB_ADR_I == ADDR_CMP1) begin
      rd_mux = cmp1_sw_r;
    end else if (WB_ADR_I == ADDR_CMP2) begin
      rd_mux = cmp2_sw_r;
    end else if (WB_ADR_I == ADDR_COUNT) begin
      rd_mux = cnt_r;
    end else begin
      rd_mux = REG_RESET;
    end
  end

  // ----------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------
  wire pwm_mode = ctrl2_r[CR2_PWM];
  wire opm_mode = ctrl2_r[CR2_ONE_PULSE] & ~pwm_mode;
  wire normal_mode = ~pwm_mode & ~opm_mode;
  wire [1:0] div_sel = ctrl2_r[CR2_DIV_HI:CR2_DIV_LO];
  wire lvl1 = ctrl1_r[CR1_LEVEL1];
  wire lvl2 = ctrl1_r[CR1_LEVEL2];
  wire pin1_en = ctrl2_r[CR2_PIN1_EN];
  wire pin2_en = ctrl2_r[CR2_PIN2_EN];

  // ----------------------------------------------------------------
  // Tick divider
  // ----------------------------------------------------------------
  wire [12:0] div_last = (div_sel == DIV_SEL_2) ? DIV_LAST_2 :
                         (div_sel == DIV_SEL_4) ? DIV_LAST_4 :
                         (div_sel == DIV_SEL_8) ? DIV_LAST_8 : DIV_LAST_8000;
  wire tick = (div_r >= div_last);
  wire [12:0] div_nxt = tick ? 13'h0000 : div_r + DIV_ONE;

  // ----------------------------------------------------------------
  // Capture edges
  // ----------------------------------------------------------------
  wire rise1 = sync1_r[1] & ~pin1_d_r;
  wire fall1 = ~sync1_r[1] & pin1_d_r;
  wire rise2 = sync2_r[1] & ~pin2_d_r;
  wire fall2 = ~sync2_r[1] & pin2_d_r;
  wire edge1 = (ctrl1_r[CR1_EDGE1] ? rise1 : fall1) & ~pwm_mode;
  wire edge2 = ctrl2_r[CR2_EDGE2] ? rise2 : fall2;

  // ----------------------------------------------------------------
  // Compare matches, one per counter value
  // ----------------------------------------------------------------
  wire late = (div_sel != DIV_SEL_2);
  wire [7:0] cmp1_eff = late ? cmp1_act_r + CMP_LATE : cmp1_act_r;
  wire [7:0] cmp2_eff = late ? cmp2_act_r + CMP_LATE : cmp2_act_r;
  wire m1 = tick_d_r & (cnt_r == cmp1_eff);
  wire m2 = tick_d_r & (cnt_r == cmp2_eff);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  wire reload = (opm_mode & edge1) | (pwm_mode & m2);
  wire wrap = tick & ~reload & (cnt_r == COUNT_MAX);
  wire [7:0] cnt_nxt = reload ? COUNT_RELOAD : tick ? cnt_r + CMP_LATE : cnt_r;

  // Active compare values follow software except in PWM, where they wait for period end
  wire [7:0] cmp1_act_nxt = (~pwm_mode | m2) ? cmp1_sw_r : cmp1_act_r;
  wire [7:0] cmp2_act_nxt = (~pwm_mode | m2) ? cmp2_sw_r : cmp2_act_r;

  // ----------------------------------------------------------------
  // Compare pins
  // ----------------------------------------------------------------
  wire force1 = wr_ctrl1 & wdata[CR1_FORCE1] & normal_mode;
  wire force2 = wr_ctrl1 & wdata[CR1_FORCE2] & normal_mode;
  logic out1_nxt, out2_nxt;
  always_comb begin
    out1_nxt = out1_r;
    out2_nxt = out2_r;
    if (pwm_mode) begin
      if (m2) begin
        out1_nxt = lvl2;
      end else if (m1) begin
        out1_nxt = lvl1;
      end
    end else if (opm_mode) begin
      if (edge1) begin
        out1_nxt = lvl2;
      end else if (m1) begin
        out1_nxt = lvl1;
      end
    end else begin
      if (force1) begin
        out1_nxt = wdata[CR1_LEVEL1];
      end else if (m1) begin
        out1_nxt = lvl1;
      end
      if (force2) begin
        out2_nxt = wdata[CR1_LEVEL2];
      end else if (m2) begin
        out2_nxt = lvl2;
      end
    end
    if (!pin1_en) begin
      out1_nxt = out1_r;
    end
    if (!pin2_en) begin
      out2_nxt = out2_r;
    end
  end

  // ----------------------------------------------------------------
  // Flags: set wins over the two-step clear
  // ----------------------------------------------------------------
  wire [NFLAGS-1:0] flag_set = {(~pwm_mode & edge1) | (pwm_mode & m2),
                                normal_mode & m1,
                                wrap,
                                edge2,
                                ~pwm_mode & m2};
  wire [NFLAGS-1:0] flag_clr = armed_r & acc_sel;
  logic [NFLAGS-1:0] flag_nxt, armed_nxt;
  genvar gi;
  generate
    for (gi = 0; gi < NFLAGS; gi++) begin : g_flag
      assign flag_nxt[gi] = flag_set[gi] | (flag_r[gi] & ~flag_clr[gi]);
      assign armed_nxt[gi] = rd_flags ? flag_r[gi] : (armed_r[gi] & ~flag_clr[gi]);
    end
  endgenerate

  wire irq_nxt = (ctrl1_r[CR1_CAP_IE] & (flag_r[FL_CAP1] | flag_r[FL_CAP2])) |
                 (ctrl1_r[CR1_CMP_IE] & (flag_r[FL_CMP1] | flag_r[FL_CMP2])) |
                 (ctrl1_r[CR1_OVF_IE] & flag_r[FL_OVF]);

  wire [7:0] cap1_nxt = (opm_mode & edge1) ? PULSE_CAPTURE :
                        (normal_mode & edge1) ? cnt_r : cap1_r;
  wire [7:0] cap2_nxt = edge2 ? cnt_r : cap2_r;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SRST) begin
      sync1_r <= 2'h0;
      sync2_r <= 2'h0;
      pin1_d_r <= 1'b0;
      pin2_d_r <= 1'b0;
    end else if (CE) begin
      sync1_r <= {sync1_r[0], CAPTURE1_IN_PIN};
      sync2_r <= {sync2_r[0], CAPTURE2_IN_PIN};
      pin1_d_r <= sync1_r[1];
      pin2_d_r <= sync2_r[1];
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      ctrl1_r <= REG_RESET;
      ctrl2_r <= REG_RESET;
      cmp1_sw_r <= REG_RESET;
      cmp2_sw_r <= REG_RESET;
    end else if (CE) begin
      if (wr_ctrl1) begin
        ctrl1_r <= wdata;
      end
      if (wr_ctrl2) begin
        ctrl2_r <= wdata & CR2_WMASK;
      end
      if (wr_cmp1) begin
        cmp1_sw_r <= wdata;
      end
      if (wr_cmp2) begin
        cmp2_sw_r <= wdata;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      div_r <= 13'h0000;
      tick_d_r <= 1'b0;
      cnt_r <= COUNT_RELOAD;
      cmp1_act_r <= REG_RESET;
      cmp2_act_r <= REG_RESET;
      cap1_r <= REG_RESET;
      cap2_r <= REG_RESET;
    end else if (CE) begin
      div_r <= div_nxt;
      tick_d_r <= tick | reload;
      cnt_r <= cnt_nxt;
      cmp1_act_r <= cmp1_act_nxt;
      cmp2_act_r <= cmp2_act_nxt;
      cap1_r <= cap1_nxt;
      cap2_r <= cap2_nxt;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      flag_r <= '0;
      armed_r <= '0;
      irq_r <= 1'b0;
      out1_r <= 1'b0;
      out2_r <= 1'b0;
      oe1_r <= 1'b0;
      oe2_r <= 1'b0;
      ack_r <= 1'b0;
      dat_r <= REG_RESET;
    end else if (CE) begin
      flag_r <= flag_nxt;
      armed_r <= armed_nxt;
      irq_r <= irq_nxt;
      out1_r <= out1_nxt;
      out2_r <= out2_nxt;
      oe1_r <= pin1_en;
      oe2_r <= pin2_en;
      ack_r <= req;
      if (req) begin
        dat_r <= rd_mux;
      end
    end
  end

  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = {24'h000000, dat_r};
  assign TIMER_IRQ = irq_r;
  assign COMPARE1_OUT_PIN = out1_r;
  assign COMPARE2_OUT_PIN = out2_r;
  assign COMPARE1_OUT_OE = oe1_r;
  assign COMPARE2_OUT_OE = oe2_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  sequence s_pwm_period_end;
    CE && pwm_mode && m2;
  endsequence

  a_pwm_counter_reload: assert property (s_pwm_period_end |=> cnt_r == COUNT_RELOAD)
    else $error("PWM period end did not reload counter");
  a_pwm_buffer_load: assert property (s_pwm_period_end |=> cmp1_act_r == $past(cmp1_sw_r))
    else $error("PWM buffer not loaded at period end");
  a_pwm_no_cmpflags: assert property (CE && pwm_mode |=> !$rose(flag_r[FL_CMP1]) && !$rose(flag_r[FL_CMP2]))
    else $error("Compare flag set in PWM mode");
  a_pwm_cap1_flag: assert property (s_pwm_period_end |=> flag_r[FL_CAP1])
    else $error("PWM period end did not set capture flag 1");
  a_opm_trigger: assert property (CE && opm_mode && edge1 |=> cnt_r == COUNT_RELOAD && cap1_r == PULSE_CAPTURE
                                  && flag_r[FL_CAP1])
    else $error("One-pulse trigger effects missing");
  a_opm_no_cmp1: assert property (CE && opm_mode && !flag_r[FL_CMP1] |=> !flag_r[FL_CMP1])
    else $error("Compare flag 1 set in one-pulse mode");
  a_overflow_wrap: assert property (CE && wrap |=> cnt_r == REG_RESET && flag_r[FL_OVF])
    else $error("Counter wrap did not set overflow flag");
  a_force_no_flag: assert property (CE && force1 && pin1_en && !m1 |=> out1_r == $past(wdata[CR1_LEVEL1])
                                    && !$rose(flag_r[FL_CMP1]))
    else $error("Forced compare misbehaved");
  a_pin_disabled: assert property (CE && !pin1_en |=> $stable(out1_r))
    else $error("Disabled compare pin changed");
  a_cmp_irq: assert property (CE && ctrl1_r[CR1_CMP_IE] && flag_r[FL_CMP2] |=> TIMER_IRQ)
    else $error("Compare flag did not raise interrupt");
  a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("Acknowledge held longer than one cycle");
endmodule

// ---- sim/timer8_pin_model.sv ----
// Pin-side partner: drives both capture inputs and resolves the compare pads.
// Assumes the board pulls each compare pad up while the timer leaves it undriven.
`timescale 1ns/100ps
module timer8_pin_model (
  input wire logic CLK,
  output logic CAPTURE1_IN_PIN,
  output logic CAPTURE2_IN_PIN,
  input wire logic COMPARE1_OUT_PIN,
  input wire logic COMPARE1_OUT_OE,
  input wire logic COMPARE2_OUT_PIN,
  input wire logic COMPARE2_OUT_OE,
  output logic PAD1,
  output logic PAD2
);
  initial begin
    CAPTURE1_IN_PIN = 1'b0;
    CAPTURE2_IN_PIN = 1'b0;
  end
  // Released pads float to the pull-up level
  assign PAD1 = COMPARE1_OUT_OE ? COMPARE1_OUT_PIN : 1'b1;
  assign PAD2 = COMPARE2_OUT_OE ? COMPARE2_OUT_PIN : 1'b1;
  task automatic set_cap(input int ch, input logic lvl);
    @(posedge CLK);
    if (ch == 1) begin
      CAPTURE1_IN_PIN <= lvl;
    end else begin
      CAPTURE2_IN_PIN <= lvl;
    end
  endtask
endmodule

// ---- sim/timer8_compare_pulse_pwm_tb.sv ----
// Self-checking bench: register accesses over Wishbone plus capture pin edges.
// Assumes the pin model above and the register map of timer8_pkg.
`timescale 1ns/100ps
module timer8_compare_pulse_pwm_tb;
  import timer8_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic [7:0] cnt;
  logic ack, cap1, cap2, pin1, oe1, pin2, oe2, irq, pad1, pad2;
  int mismatches = 0;
  int n_compared = 0;
  int n_neg = 0;
  int t0;
  always #4 clk = ~clk;
  always @(negedge clk) n_neg++;
  timer8_compare_pulse_pwm u_dut (.CLK(clk), .SRST(srst), .CE(1'b1), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .CAPTURE1_IN_PIN(cap1), .CAPTURE2_IN_PIN(cap2), .COMPARE1_OUT_PIN(pin1), .COMPARE1_OUT_OE(oe1),
    .COMPARE2_OUT_PIN(pin2), .COMPARE2_OUT_OE(oe2), .TIMER_IRQ(irq));
  timer8_pin_model u_pins (.CLK(clk), .CAPTURE1_IN_PIN(cap1), .CAPTURE2_IN_PIN(cap2),
    .COMPARE1_OUT_PIN(pin1), .COMPARE1_OUT_OE(oe1), .COMPARE2_OUT_PIN(pin2), .COMPARE2_OUT_OE(oe2),
    .PAD1(pad1), .PAD2(pad2));
  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    // Hold the request until a rising edge samples ack high, then take data and release there
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    chk("ack", 1'b1, ack);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    bus(a, 1'b0, 8'h00);
    chk(nm, {24'h0, e}, q);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Waits, bounded, for compare pad 1 to reach a level
  task automatic wait_pad(input logic lvl);
    int n;
    n = 0;
    while (pad1 !== lvl && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk("pad1", lvl, pad1);
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    end_sim();
  end
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    idle(1);
    chk("outputs", 5'h00, {pin1, oe1, pin2, oe2, irq});
    rd(ADDR_CTRL1, 8'h00, "ctrl1");
    rd(ADDR_CTRL2, 8'h00, "ctrl2");
    rd(ADDR_CMP2, 8'h00, "cmp2");
    rd(8'h20, 8'h00, "unmapped");
    idle(1100);
    rd(ADDR_FLAGS, 8'h68, "flags wrap");
    wr(ADDR_CTRL1, 8'h20);
    idle(2);
    chk("irq ovf", 1'b1, irq);
    bus(ADDR_COUNT, 1'b0, 8'h00);
    bus(ADDR_CMP1, 1'b1, 8'h00);
    bus(ADDR_CMP2, 1'b1, 8'h00);
    rd(ADDR_FLAGS, 8'h00, "flags cleared");
    chk("irq off", 1'b0, irq);
    $display("test reset and overflow done");
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_CTRL2, i ? 8'h88 : 8'h84);
      wr(ADDR_CTRL1, i ? 8'h44 : 8'h45);
      bus(ADDR_COUNT, 1'b0, 8'h00);
      cnt = q[7:0] + 8'h10;
      wr(ADDR_CMP1, cnt);
      wr(ADDR_CMP2, cnt);
      wait_pad(i ? 1'b0 : 1'b1);
      rd(ADDR_COUNT, cnt + 8'h01, "count at match");
      rd(ADDR_FLAGS, 8'h48, "compare flags");
      chk("pin2 free", 3'b001, {oe2, pin2, pad2});
      wr(ADDR_CMP1, cnt);
      idle(2);
      chk("irq flag2", 1'b1, irq);
      wr(ADDR_CMP2, cnt);
      idle(2);
      chk("irq clear", 1'b0, irq);
    end
    $display("test compare done");
    wr(ADDR_CTRL2, 8'h8C);
    wr(ADDR_CTRL1, 8'h09);
    idle(1);
    chk("forced high", 1'b1, pad1);
    rd(ADDR_FLAGS, 8'h00, "no force flag");
    wr(ADDR_CTRL2, 8'hAC);
    wr(ADDR_CTRL1, 8'h08);
    idle(1);
    chk("force in pulse", 1'b1, pad1);
    wr(ADDR_CTRL2, 8'h9C);
    wr(ADDR_CTRL1, 8'h08);
    idle(1);
    chk("force in pwm", 1'b1, pad1);
    $display("test forced compare done");
    wr(ADDR_CMP1, 8'h20);
    wr(ADDR_CMP2, 8'h10);
    wr(ADDR_CTRL2, 8'h86);
    wr(ADDR_CTRL1, 8'h8E);
    wr(ADDR_CTRL2, 8'hE6);
    idle(1);
    chk("pad before", 1'b0, pad1);
    u_pins.set_cap(1, 1'b1);
    wait_pad(1'b1);
    t0 = n_neg;
    wait_pad(1'b0);
    chk("pulse width", 1'b1, (n_neg - t0 >= 71) && (n_neg - t0 <= 74));
    chk("irq capture", 1'b1, irq);
    rd(ADDR_CAP1, 8'hFD, "trigger capture");
    rd(ADDR_FLAGS, 8'hA8, "pulse flags");
    chk("pin2 idle", 2'b10, {oe2, pad2});
    rd(ADDR_CAP1, 8'hFD, "capture clear");
    rd(ADDR_FLAGS, 8'h28, "capture1 cleared");
    u_pins.set_cap(1, 1'b0);
    idle(20);
    chk("falling ignored", 1'b0, pad1);
    u_pins.set_cap(2, 1'b1);
    idle(10);
    rd(ADDR_FLAGS, 8'h38, "capture2 flag");
    wr(ADDR_CTRL1, 8'h87);
    u_pins.set_cap(1, 1'b1);
    idle(10);
    chk("equal levels", 1'b1, pad1);
    idle(80);
    chk("equal levels late", 1'b1, pad1);
    $display("test one pulse done");
    wr(ADDR_CTRL1, 8'h81);
    wr(ADDR_CTRL2, 8'hB4);
    bus(ADDR_FLAGS, 1'b0, 8'h00);
    wr(ADDR_CMP1, 8'h10);
    wr(ADDR_CMP2, 8'h30);
    bus(ADDR_CAP1, 1'b0, 8'h00);
    bus(ADDR_CAP2, 1'b0, 8'h00);
    bus(ADDR_COUNT, 1'b0, 8'h00);
    repeat (2) begin
      wait_pad(1'b0);
      wait_pad(1'b1);
    end
    t0 = n_neg;
    wait_pad(1'b0);
    chk("pwm high", 32'd64, n_neg - t0);
    t0 = n_neg;
    wait_pad(1'b1);
    chk("pwm low", 32'd40, n_neg - t0);
    t0 = n_neg;
    wr(ADDR_CMP2, 8'h40);
    wait_pad(1'b0);
    chk("buffered high", 32'd64, n_neg - t0);
    rd(ADDR_FLAGS, 8'hA0, "pwm flags");
    chk("irq pwm", 1'b1, irq);
    wait_pad(1'b1);
    t0 = n_neg;
    u_pins.set_cap(1, 1'b0);
    wait_pad(1'b0);
    chk("new high", 32'd96, n_neg - t0);
    $display("test pwm done");
    end_sim();
  end
endmodule
